// [core/tcav_top.sv]
// Purpose: One channel's function lines, supervision and backplane relays.
// Assumes: Binary inputs arrive from pins and are synchronised here; neighbour lines arrive already synchronised.
// Notes:   Registers are 32-bit words on a plain strobe port.

module tcav_top #(
    parameter int SETTLE   = tcav_pkg::SETTLE_CYCLES,
    parameter int LEVEL_W  = tcav_pkg::LEVEL_W,
    parameter int AGREE_TOL = 16'h0400
) (
    input  wire logic               mclk,
    input  wire logic               srst,
    input  wire logic               clkEn,
    input  wire logic [3:0]         regAddr,
    input  wire logic [31:0]        regWdata,
    input  wire logic               regWr,
    input  wire logic               regRd,
    output logic      [31:0]        regRdata,
    input  wire logic [LEVEL_W-1:0] measValue,
    input  wire logic               extBlockPin,
    input  wire logic               latchResetPin,
    input  wire logic               testEnablePin,
    input  wire logic               testSelectOnePin,
    input  wire logic               testSelectTwoPin,
    input  wire logic [LEVEL_W-1:0] neighbourCurA,
    input  wire logic [LEVEL_W-1:0] neighbourCurB,
    input  wire logic [2:0]         peerLine1,
    input  wire logic [2:0]         peerLine2,
    input  wire logic [2:0]         peerLine3,
    input  wire logic [2:0]         peerLine4,
    input  wire logic [2:0]         peerTrip,
    input  wire logic [2:0]         peerHealthy,
    output logic      [5:0]         functionLine,
    output logic                    channelHealthy,
    output logic      [5:0]         lineLamp,
    output logic      [1:0]         disagreeLamp,
    output logic      [LEVEL_W-1:0] isolatedCurrentDrive,
    output logic      [LEVEL_W-1:0] groundedCurrentDrive,
    output logic      [5:0]         relay
);
    localparam int N = tcav_pkg::NUM_LINES;

    // Two-stage synchronisers for the five binary pins.
    logic [4:0] pinMeta;
    logic [4:0] pinSync;
    logic [4:0] next_pinMeta;
    logic [4:0] next_pinSync;
    always_comb begin
        next_pinMeta = {testSelectTwoPin, testSelectOnePin, testEnablePin,
                        latchResetPin, extBlockPin};
        next_pinSync = pinMeta;
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            pinMeta <= 5'h00;
            pinSync <= 5'h00;
        end else if (clkEn) begin
            pinMeta <= next_pinMeta;
            pinSync <= next_pinSync;
        end
    end
    logic extBlock;
    logic latchReset;
    logic testEnable;
    logic testSelectOne;
    logic testSelectTwo;
    assign extBlock      = pinSync[0];
    assign latchReset    = pinSync[1];
    assign testEnable    = pinSync[2];
    assign testSelectOne = pinSync[3];
    assign testSelectTwo = pinSync[4];

    // Registers.
    logic [31:0]        ctrl;
    logic [LEVEL_W-1:0] testVal1;
    logic [LEVEL_W-1:0] testVal2;
    logic [1:0]         curCfg;
    logic [31:0]        lineCfg [N];
    logic [31:0]        next_ctrl;
    logic [LEVEL_W-1:0] next_testVal1;
    logic [LEVEL_W-1:0] next_testVal2;
    logic [1:0]         next_curCfg;
    logic [31:0]        next_lineCfg [N];
    logic [31:0]        next_regRdata;
    logic [31:0]        statusWord;

    always_comb begin
        next_ctrl     = ctrl;
        next_testVal1 = testVal1;
        next_testVal2 = testVal2;
        next_curCfg   = curCfg;
        next_lineCfg  = lineCfg;
        next_regRdata = 32'h0000_0000;
        if (regWr) begin
            unique case (regAddr)
                tcav_pkg::ADDR_CTRL:     next_ctrl = regWdata & 32'h0000_0007;
                tcav_pkg::ADDR_TESTVAL1: next_testVal1 = regWdata[LEVEL_W-1:0];
                tcav_pkg::ADDR_TESTVAL2: next_testVal2 = regWdata[LEVEL_W-1:0];
                tcav_pkg::ADDR_CURCFG:   next_curCfg = regWdata[1:0];
                default: begin
                    if (regAddr >= tcav_pkg::ADDR_LINE0 &&
                        regAddr < tcav_pkg::ADDR_LINE0 + 4'(N)) begin
                        next_lineCfg[3'(regAddr - tcav_pkg::ADDR_LINE0)] = regWdata;
                    end
                end
            endcase
        end
        if (regRd) begin
            unique case (regAddr)
                tcav_pkg::ADDR_CTRL:     next_regRdata = ctrl;
                tcav_pkg::ADDR_STATUS:   next_regRdata = statusWord;
                tcav_pkg::ADDR_TESTVAL1: next_regRdata = 32'(testVal1);
                tcav_pkg::ADDR_TESTVAL2: next_regRdata = 32'(testVal2);
                tcav_pkg::ADDR_CURCFG:   next_regRdata = 32'(curCfg);
                default: begin
                    if (regAddr >= tcav_pkg::ADDR_LINE0 &&
                        regAddr < tcav_pkg::ADDR_LINE0 + 4'(N)) begin
                        next_regRdata = lineCfg[3'(regAddr - tcav_pkg::ADDR_LINE0)];
                    end
                end
            endcase
        end
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl     <= tcav_pkg::CTRL_RESET;
            testVal1 <= '0;
            testVal2 <= '0;
            curCfg   <= 2'h0;
            for (int i = 0; i < N; i++) lineCfg[i] <= 32'h0000_0000;
            regRdata <= 32'h0000_0000;
        end else if (clkEn) begin
            ctrl     <= next_ctrl;
            testVal1 <= next_testVal1;
            testVal2 <= next_testVal2;
            curCfg   <= next_curCfg;
            lineCfg  <= next_lineCfg;
            regRdata <= next_regRdata;
        end
    end

    // Settling delay: counts down to zero and holds there while the module is healthy.
    logic        moduleFault;
    logic [31:0] settleCnt;
    logic [31:0] next_settleCnt;
    logic        blocked;
    assign moduleFault = ctrl[tcav_pkg::CTRL_FAULT];
    always_comb begin
        if (moduleFault) next_settleCnt = 32'(SETTLE);
        else if (settleCnt != 32'h0000_0000) next_settleCnt = settleCnt - 32'h0000_0001;
        else next_settleCnt = settleCnt;
    end
    always_ff @(posedge mclk) begin
        if (srst) settleCnt <= 32'(SETTLE);
        else if (clkEn) settleCnt <= next_settleCnt;
    end
    assign blocked = (settleCnt != 32'h0000_0000) || moduleFault;

    // Measurement substitution.
    logic [LEVEL_W-1:0] evalValue;
    always_comb begin
        evalValue = measValue;
        if (testEnable && testSelectOne) evalValue = testVal1;
        else if (testEnable && testSelectTwo) evalValue = testVal2;
    end

    // Function lines.
    logic [N-1:0] lineState;
    logic [N-1:0] next_lineState;
    logic [N-1:0] cond;
    for (genvar g = 0; g < N; g++) begin : gLine
        tcav_pkg::tcav_src_t  src;
        tcav_pkg::tcav_mode_t mode;
        logic [LEVEL_W-1:0]   lim;
        logic                 over;
        assign src  = tcav_pkg::tcav_src_t'(lineCfg[g][tcav_pkg::LINE_SRC_LSB +: 2]);
        assign mode = tcav_pkg::tcav_mode_t'(lineCfg[g][tcav_pkg::LINE_MODE_LSB +: 2]);
        assign lim  = lineCfg[g][tcav_pkg::LINE_LIMIT_LSB +: LEVEL_W];
        assign over = lineCfg[g][tcav_pkg::LINE_FALL] ? (evalValue < lim)
                                                      : (evalValue > lim);
        always_comb begin
            unique case (src)
                tcav_pkg::TCAV_SRC_MEAS:  cond[g] = over;
                tcav_pkg::TCAV_SRC_FAULT: cond[g] = moduleFault;
                tcav_pkg::TCAV_SRC_TEST_SELECT_ONE: cond[g] = testEnable & testSelectOne;
                tcav_pkg::TCAV_SRC_TEST_SELECT_TWO: cond[g] = testEnable & testSelectTwo;
            endcase
            unique case (mode)
                tcav_pkg::TCAV_MODE_LIMIT: next_lineState[g] = cond[g] & ~blocked;
                tcav_pkg::TCAV_MODE_LATCH: next_lineState[g] =
                    (cond[g] & ~blocked) | (lineState[g] & ~latchReset);
                default:                   next_lineState[g] = 1'b0;
            endcase
        end
    end
    always_ff @(posedge mclk) begin
        if (srst) lineState <= '0;
        else if (clkEn) lineState <= next_lineState;
    end
    assign functionLine = extBlock ? 6'h00 : lineState;
    assign lineLamp     = functionLine;

    logic healthyLevel;
    assign healthyLevel   = ~blocked;
    assign channelHealthy = healthyLevel ^ ctrl[tcav_pkg::CTRL_HEALTHYPOL];

    // Current drive and neighbour comparison.
    logic [LEVEL_W-1:0] curCode;
    logic [LEVEL_W-1:0] next_curCode;
    logic [1:0]         disagree;
    logic [1:0]         next_disagree;
    logic [LEVEL_W-1:0] span;
    always_comb begin
        span = curCfg[tcav_pkg::CUR_LIVEZERO] ? 16'hFFFF - tcav_pkg::LIVE_ZERO_CODE
                                              : 16'hFFFF;
        next_curCode = LEVEL_W'((32'(evalValue) * 32'(span)) >> LEVEL_W);
        if (curCfg[tcav_pkg::CUR_FALL]) next_curCode = span - next_curCode;
        if (curCfg[tcav_pkg::CUR_LIVEZERO])
            next_curCode = next_curCode + tcav_pkg::LIVE_ZERO_CODE;
        next_disagree[0] = ((neighbourCurA > curCode) ? neighbourCurA - curCode
                            : curCode - neighbourCurA) > LEVEL_W'(AGREE_TOL);
        next_disagree[1] = ((neighbourCurB > curCode) ? neighbourCurB - curCode
                            : curCode - neighbourCurB) > LEVEL_W'(AGREE_TOL);
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            curCode  <= '0;
            disagree <= 2'h0;
        end else if (clkEn) begin
            curCode  <= next_curCode;
            disagree <= next_disagree;
        end
    end
    assign isolatedCurrentDrive = curCode;
    assign groundedCurrentDrive = curCode;
    assign disagreeLamp         = disagree;
    assign statusWord = {22'h0, disagree, lineState, blocked, moduleFault};

    tcav_vote uVote (
        .variantAlt (ctrl[tcav_pkg::CTRL_VARIANT]),
        .line1      (peerLine1),
        .line2      (peerLine2),
        .line3      (peerLine3),
        .line4      (peerLine4),
        .trip       (peerTrip),
        .healthy    (peerHealthy),
        .relay      (relay)
    );

    a_latch_holds: assert property (@(posedge mclk) disable iff (srst)
        clkEn && lineState[2] && lineCfg[2][tcav_pkg::LINE_MODE_LSB +: 2] == 2'b10
        && !latchReset |=> lineState[2]) else $error("Latched line dropped without reset.");
    a_latch_clear: assert property (@(posedge mclk) disable iff (srst)
        clkEn && latchReset && blocked |=> lineState == '0)
        else $error("Latch reset did not clear lines.");
    a_block_lines: assert property (@(posedge mclk) disable iff (srst)
        extBlock |-> functionLine == 6'h00) else $error("Lines active while blocked.");
    a_settle_gate: assert property (@(posedge mclk) disable iff (srst)
        clkEn && blocked |=> (lineState & ~$past(lineState)) == '0)
        else $error("Settle gating failed.");
    a_settle_reload: assert property (@(posedge mclk) disable iff (srst)
        clkEn && moduleFault |=> settleCnt == 32'(SETTLE))
        else $error("Settle counter not reloaded.");
    a_maj_relay: assert property (@(posedge mclk) disable iff (srst)
        !ctrl[0] |-> relay[0] == ($countones(peerLine1) >= 2))
        else $error("Line one vote wrong.");
    a_any_healthy: assert property (@(posedge mclk) disable iff (srst)
        !ctrl[0] |-> relay[4] == (peerHealthy != 3'h0)) else $error("Healthy any wrong.");
    a_alt_relay: assert property (@(posedge mclk) disable iff (srst)
        ctrl[0] |-> relay[4:2] == (peerTrip | peerHealthy)) else $error("Trip relay wrong.");
    a_alt_vote: assert property (@(posedge mclk) disable iff (srst)
        ctrl[0] |-> relay[1] == ($countones(peerLine4) >= 2)) else $error("Line four vote wrong.");
    a_healthy_pol: assert property (@(posedge mclk) disable iff (srst)
        channelHealthy == (!blocked ^ ctrl[1])) else $error("Healthy polarity wrong.");
endmodule

// [core/tcav_pkg.sv]
// Purpose: Shared constants and types for the three-channel alarm voting block.
// Assumes: 100 MHz clock on mclk.
// Notes:   Register offsets index a plain strobe port with 32-bit data.
package tcav_pkg;
    localparam int          CLK_HZ          = 100_000_000;
    localparam int          SETTLE_SEC      = 5;
    localparam int          SETTLE_CYCLES   = SETTLE_SEC * CLK_HZ;
    localparam int          NUM_LINES       = 6;
    localparam int          LEVEL_W         = 16;
    localparam logic [3:0]  ADDR_CTRL       = 4'h0;
    localparam logic [3:0]  ADDR_STATUS     = 4'h1;
    localparam logic [3:0]  ADDR_TESTVAL1   = 4'h2;
    localparam logic [3:0]  ADDR_TESTVAL2   = 4'h3;
    localparam logic [3:0]  ADDR_CURCFG     = 4'h4;
    localparam logic [3:0]  ADDR_LINE0      = 4'h8;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
    localparam int          CTRL_VARIANT    = 0;
    localparam int          CTRL_HEALTHYPOL = 1;
    localparam int          CTRL_FAULT      = 2;
    localparam int          LINE_LIMIT_LSB  = 0;
    localparam int          LINE_SRC_LSB    = 16;
    localparam int          LINE_MODE_LSB   = 20;
    localparam int          LINE_FALL       = 22;
    localparam int          CUR_FALL        = 0;
    localparam int          CUR_LIVEZERO    = 1;
    localparam logic [15:0] LIVE_ZERO_CODE  = 16'h3333;

    typedef enum logic [1:0] {
        TCAV_MODE_OFF   = 2'b00,
        TCAV_MODE_LIMIT = 2'b01,
        TCAV_MODE_LATCH = 2'b10
    } tcav_mode_t;

    typedef enum logic [1:0] {
        TCAV_SRC_MEAS  = 2'b00,
        TCAV_SRC_FAULT = 2'b01,
        TCAV_SRC_TEST_SELECT_ONE = 2'b10,
        TCAV_SRC_TEST_SELECT_TWO = 2'b11
    } tcav_src_t;
endpackage

// [core/tcav_vote.sv]
// Purpose: Backplane relay voting across three channels.
// Assumes: Inputs are already synchronised.
// Notes:   Purely combinational.
module tcav_vote (
    input  wire logic       variantAlt,
    input  wire logic [2:0] line1,
    input  wire logic [2:0] line2,
    input  wire logic [2:0] line3,
    input  wire logic [2:0] line4,
    input  wire logic [2:0] trip,
    input  wire logic [2:0] healthy,
    output logic      [5:0] relay
);
    function automatic logic maj3(input logic [2:0] v);
        return (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
    endfunction

    always_comb begin
        relay = 6'h00;
        if (!variantAlt) begin
            relay[0] = maj3(line1);
            relay[1] = maj3(line2);
            relay[2] = maj3(line3);
            relay[3] = maj3(healthy);
            relay[4] = |healthy;
        end else begin
            relay[0] = maj3(line2);
            relay[1] = maj3(line4);
            relay[4:2] = trip | healthy;
        end
    end
endmodule

// [tb/tcav_peers.sv]
// Purpose: Model of the two neighbour channels and the backplane peer lines.
// Assumes: One clock, synchronous reset, peers switch right after a rising edge.
// Notes:   Neighbour currents follow the own current; skewA pulls neighbour A off.
module tcav_peers (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        run,
    input  wire logic [15:0] ownCur,
    input  wire logic [15:0] skewA,
    output logic      [15:0] curA,
    output logic      [15:0] curB,
    output logic      [2:0]  line1,
    output logic      [2:0]  line2,
    output logic      [2:0]  line3,
    output logic      [2:0]  line4,
    output logic      [2:0]  trip,
    output logic      [2:0]  healthy
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [17:0] state;
    // A shift register, stepped only while run is high, walks pseudo-randomly through peer line combinations.
    always_ff @(posedge mclk) begin
        if (srst) state <= 18'h2A5C3;
        else if (run) state <= {state[16:0], state[17] ^ state[10]} ^ {state[8:0], 9'h000};
    end
    assign {healthy, trip, line4, line3, line2, line1} = state;
    assign curA = ownCur + skewA;
    assign curB = ownCur;
endmodule

// [tb/tcav_top_bench.sv]
// Purpose: Self-checking bench for one channel with voting relays.
// Assumes: Settling delay shortened to 20 cycles through the parameter.
// Notes:   Random limits and measurements come from a fixed seed.
module tcav_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SETTLE = 20;
    logic mclk = 1'b0, srst = 1'b1, regWr = 1'b0, regRd = 1'b0, run = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0, regRdata, rd;
    logic [15:0] measValue = 16'h0, skewA = 16'h0, curA, curB, isoCur, gndCur, lim;
    logic extBlockPin = 1'b0, latchResetPin = 1'b0, testEnablePin = 1'b0;
    logic testSelectOnePin = 1'b0, testSelectTwoPin = 1'b0, channelHealthy;
    logic [2:0] line1, line2, line3, line4, trip, healthy;
    logic [5:0] functionLine, lineLamp, relay;
    logic [1:0] disagreeLamp;
    int numErrors = 0, checks = 0;
    always #5 mclk = ~mclk;
    tcav_peers peers (.mclk(mclk), .srst(srst), .run(run), .ownCur(isoCur), .skewA(skewA),
        .curA(curA), .curB(curB), .line1(line1), .line2(line2), .line3(line3),
        .line4(line4), .trip(trip), .healthy(healthy));
    tcav_top #(.SETTLE(SETTLE)) dut (.mclk(mclk), .srst(srst), .clkEn(1'b1),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .measValue(measValue), .extBlockPin(extBlockPin),
        .latchResetPin(latchResetPin), .testEnablePin(testEnablePin),
        .testSelectOnePin(testSelectOnePin), .testSelectTwoPin(testSelectTwoPin),
        .neighbourCurA(curA), .neighbourCurB(curB), .peerLine1(line1), .peerLine2(line2),
        .peerLine3(line3), .peerLine4(line4), .peerTrip(trip), .peerHealthy(healthy),
        .functionLine(functionLine), .channelHealthy(channelHealthy), .lineLamp(lineLamp),
        .disagreeLamp(disagreeLamp), .isolatedCurrentDrive(isoCur),
        .groundedCurrentDrive(gndCur), .relay(relay));
    function automatic logic maj(input logic [2:0] v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction
    function automatic logic [5:0] expRelay(input logic alt);
        if (alt) return {1'b0, trip | healthy, maj(line4), maj(line2)};
        return {1'b0, |healthy, maj(healthy), maj(line3), maj(line2), maj(line1)};
    endfunction
    function automatic logic [31:0] lineCfg(input logic [15:0] l, input logic [1:0] m,
                                            input logic f);
        return {16'h0, l} | ({30'h0, m} << tcav_pkg::LINE_MODE_LSB)
            | ({31'h0, f} << tcav_pkg::LINE_FALL);
    endfunction
    task automatic giveVerdict();
        $display("Comparisons %0d, mismatches %0d", checks, numErrors);
        if (numErrors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            numErrors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task automatic regRead(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask
    // Lines pass through pin synchronisers, so the wait is bounded, not fixed.
    task automatic waitLines(input string what, input logic [5:0] mask, input logic [5:0] e);
        for (int k = 0; k < 40 && (functionLine & mask) !== e; k++) @(negedge mclk);
        check(what, {26'h0, functionLine & mask}, {26'h0, e});
        check("lineLamp", {26'h0, lineLamp}, {26'h0, functionLine});
        @(posedge mclk);
    endtask
    task automatic waitSettled();
        for (int k = 0; k < 60; k++) begin
            regRead(tcav_pkg::ADDR_STATUS, rd);
            if (rd[1] === 1'b0) break;
        end
        check("blocked", {31'h0, rd[1]}, 32'h0);
    endtask
    task automatic pulse(ref logic pin);
        @(posedge mclk) pin <= 1'b1;
        repeat (4) @(posedge mclk);
        pin <= 1'b0;
    endtask
    initial begin
        repeat (100000) @(posedge mclk);
        numErrors++;
        $display("MISMATCH run length expected finish seen timeout");
        giveVerdict();
    end
    initial begin
        void'($urandom(32'hE17F));
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        regRead(tcav_pkg::ADDR_STATUS, rd);
        check("blocked at start", {31'h0, rd[1]}, 32'h1);
        check("healthy while blocked", {31'h0, channelHealthy}, 32'h0);
        regRead(tcav_pkg::ADDR_CTRL, rd);
        check("ctrl reset", rd, tcav_pkg::CTRL_RESET);
        regRead(4'h7, rd);
        check("unmapped read", rd, 32'h0);
        waitSettled();
        check("healthy settled", {31'h0, channelHealthy}, 32'h1);
        run <= 1'b1;
        for (int i = 0; i < 300; i++) begin
            if (i == 150) regWrite(tcav_pkg::ADDR_CTRL, 32'h1);
            @(negedge mclk);
            check("relay", {26'h0, relay}, {26'h0, expRelay(i >= 150)});
        end
        run <= 1'b0;
        regWrite(tcav_pkg::ADDR_CTRL, 32'h0);
        lim = 16'($urandom_range(32'h2000, 32'hC000));
        regWrite(tcav_pkg::ADDR_LINE0, lineCfg(lim, tcav_pkg::TCAV_MODE_LIMIT, 1'b0));
        regWrite(tcav_pkg::ADDR_LINE0 + 4'h1, lineCfg(lim, tcav_pkg::TCAV_MODE_LIMIT, 1'b1));
        regWrite(tcav_pkg::ADDR_LINE0 + 4'h2, lineCfg(lim, tcav_pkg::TCAV_MODE_LATCH, 1'b0));
        measValue <= lim + 16'($urandom_range(32'h100, 32'h1000));
        waitLines("above limit", 6'h3F, 6'h05);
        measValue <= lim - 16'($urandom_range(32'h100, 32'h1000));
        waitLines("below limit", 6'h3F, 6'h06);
        pulse(latchResetPin);
        waitLines("latch reset", 6'h3F, 6'h02);
        extBlockPin <= 1'b1;
        waitLines("external block", 6'h3F, 6'h00);
        extBlockPin <= 1'b0;
        waitLines("block released", 6'h3F, 6'h02);
        regWrite(tcav_pkg::ADDR_TESTVAL1, {16'h0, lim + 16'h0200});
        regWrite(tcav_pkg::ADDR_TESTVAL2, {16'h0, lim - 16'h0200});
        testSelectOnePin <= 1'b1;
        waitLines("select without enable", 6'h03, 6'h02);
        testEnablePin <= 1'b1;
        waitLines("test value one", 6'h03, 6'h01);
        testSelectOnePin <= 1'b0;
        testSelectTwoPin <= 1'b1;
        waitLines("test value two", 6'h03, 6'h02);
        {testEnablePin, testSelectTwoPin} <= 2'b00;
        regWrite(tcav_pkg::ADDR_CTRL, 32'h2);
        #1 check("healthy inverted", {31'h0, channelHealthy}, 32'h0);
        regWrite(tcav_pkg::ADDR_CTRL, 32'h4);
        regRead(tcav_pkg::ADDR_STATUS, rd);
        check("fault status", {30'h0, rd[1:0]}, 32'h3);
        // The latch set by test value one survives blocking, so clear it while blocked.
        pulse(latchResetPin);
        waitLines("fault blocks lines", 6'h3F, 6'h00);
        regWrite(tcav_pkg::ADDR_CTRL, 32'h0);
        regRead(tcav_pkg::ADDR_STATUS, rd);
        check("recovery blocked", {30'h0, rd[1:0]}, 32'h2);
        waitSettled();
        measValue <= 16'h0000;
        regWrite(tcav_pkg::ADDR_CURCFG, 32'h0);
        for (int k = 0; k < 40 && isoCur !== 16'h0000; k++) @(negedge mclk);
        check("current zero based", {16'h0, isoCur}, 32'h0);
        regWrite(tcav_pkg::ADDR_CURCFG, 32'h2);
        for (int k = 0; k < 40 && isoCur !== tcav_pkg::LIVE_ZERO_CODE; k++) @(negedge mclk);
        check("current live zero", {16'h0, isoCur}, {16'h0, tcav_pkg::LIVE_ZERO_CODE});
        check("grounded equals isolated", {16'h0, gndCur}, {16'h0, isoCur});
        for (int k = 0; k < 40 && disagreeLamp !== 2'b00; k++) @(negedge mclk);
        check("agree", {30'h0, disagreeLamp}, 32'h0);
        @(posedge mclk);
        skewA <= 16'h2000;
        for (int k = 0; k < 40 && disagreeLamp !== 2'b01; k++) @(negedge mclk);
        check("disagree A", {30'h0, disagreeLamp}, 32'h1);
        regWrite(tcav_pkg::ADDR_CURCFG, 32'h1);
        for (int k = 0; k < 40 && isoCur !== 16'hFFFF; k++) @(negedge mclk);
        check("current falling", {16'h0, isoCur}, 32'h0000_FFFF);
        giveVerdict();
    end
endmodule
